// ==== core/erbf_pkg.sv ====
// Purpose: Shared constants and types of the receive buffer/teardown/filter
// Assumes: 32-bit register port, word-aligned offsets, eight channels
// Notes:   Offsets are byte addresses on the plain register port
package erbf_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_FILTER_CFG   = 8'h00;
  localparam logic [7:0] OFS_MAX_LEN      = 8'h04;
  localparam logic [7:0] OFS_LOW_THRESH   = 8'h08;
  localparam logic [7:0] OFS_CHAN_ENABLE  = 8'h0c;
  localparam logic [7:0] OFS_SHUTDOWN_CMD = 8'h10;
  localparam logic [7:0] OFS_INT_STATUS   = 8'h14;
  localparam logic [2:0] REGION_CONFIG    = 3'h0;
  localparam logic [2:0] REGION_FREE_CNT  = 3'h2;
  localparam logic [2:0] REGION_COMPL_PTR = 3'h3;
  localparam logic [2:0] REGION_HEAD_PTR  = 3'h4;

  // ==========================================================
  // Filter configuration field positions
  localparam int CFG_KEEP_FCS     = 0;
  localparam int CFG_ERROR_EN     = 1;
  localparam int CFG_ALL_EN       = 2;
  localparam int CFG_CONTROL_EN   = 3;
  localparam int CFG_SHORT_EN     = 4;
  localparam int CFG_QOS_EN       = 5;
  localparam int CFG_CATCHALL_LSB = 8;

  // ==========================================================
  // Reset values and fixed figures
  localparam logic [15:0] MAX_LEN_RESET   = 16'h05ee;
  localparam logic [15:0] MIN_FRAME_LEN   = 16'h0040;
  localparam logic [15:0] SHORT_CRC_LEN   = 16'h0014;
  localparam logic [15:0] FCS_BYTES       = 16'h0004;
  localparam logic [31:0] SHUTDOWN_CODE   = 32'hffff_fffc;
  localparam logic [15:0] FREE_CNT_MAX    = 16'hffff;
  localparam logic [2:0]  HIGH_PRIO_MIN   = 3'h4;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SD_IDLE  = 3'b000,
    SD_WAIT  = 3'b001,
    SD_MARK  = 3'b011,
    SD_CLEAR = 3'b010,
    SD_DONE  = 3'b110
  } erbf_state_t;

  typedef enum logic [2:0] {
    CLS_PROPER    = 3'h0,
    CLS_OVERSIZE  = 3'h1,
    CLS_JABBER    = 3'h2,
    CLS_UNDERSIZE = 3'h3,
    CLS_FRAGMENT  = 3'h4,
    CLS_BAD_CRC   = 3'h5
  } erbf_class_t;

endpackage : erbf_pkg

// ==== core/erbf_free_count_bank.sv ====
// Purpose: Per-channel free-buffer counters, add by host, consume by DMA
// Assumes: One add and one consume per cycle at most
// Notes:   Counts saturate at both ends
`timescale 1ns/10ps
module erbf_free_count_bank
  import erbf_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int CH_W   = 3,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  // Host additions
  input  wire logic                    add_we_i,
  input  wire logic [CH_W-1:0]         add_ch_i,
  input  wire logic [CNT_W-1:0]        add_val_i,
  // Buffer consumption
  input  wire logic                    use_i,
  input  wire logic [CH_W-1:0]         use_ch_i,
  // Counts
  output logic      [NUM_CH*CNT_W-1:0] count_o
);

  if (CNT_W < 16 || NUM_CH != (1 << CH_W)) begin : g_param_check
    $error("erbf_free_count_bank: unsupported parameters");
  end

  // ==========================================================
  // Counters
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_cnt
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W:0]   sum;
    logic             hit_add;
    logic             hit_use;

    assign hit_add = add_we_i && (add_ch_i == CH_W'(ch));
    assign hit_use = use_i && (use_ch_i == CH_W'(ch));
    // Write adds rather than replaces room for full range
    assign sum = {1'b0, cnt_q} + {1'b0, (hit_add ? add_val_i : '0)};

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        cnt_q <= '0;
      end else if (hit_add || hit_use) begin
        if (sum[CNT_W]) begin
          cnt_q <= {CNT_W{1'b1}};
        end else if (hit_use && sum[CNT_W-1:0] != '0) begin
          cnt_q <= sum[CNT_W-1:0] - CNT_W'(1);
        end else if (hit_use) begin
          cnt_q <= '0; // Hold at zero, no wrap
        end else begin
          cnt_q <= sum[CNT_W-1:0];
        end
      end
    end

    assign count_o[ch*CNT_W +: CNT_W] = cnt_q;
  end

endmodule // erbf_free_count_bank

// ==== core/erbf_top.sv ====
// Purpose: Receive free-buffer tracking, channel shutdown, frame filter
// Assumes: Front-end inputs come from logic on sys_clk_i
// Notes:   Register data read back one cycle after the read strobe
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module erbf_top
  import erbf_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int CH_W   = 3,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // Receive DMA buffer use
  input  wire logic              buf_used_i,
  input  wire logic [CH_W-1:0]   buf_used_ch_i,
  input  wire logic              rx_frame_busy_i,
  // Frame end report from receive front end
  input  wire logic              frame_end_i,
  input  wire logic [15:0]       frame_len_i,
  input  wire logic              crc_err_i,
  input  wire logic              code_err_i,
  input  wire logic              align_err_i,
  input  wire logic              control_frame_i,
  input  wire logic              vlan_tagged_i,
  input  wire logic [2:0]        vlan_prio_i,
  input  wire logic              addr_hit_i,
  input  wire logic              match_or_drop_bit_i,
  input  wire logic [CH_W-1:0]   addr_hit_ch_i,
  // Frame decision
  output logic                   dec_valid_o,
  output logic                   dec_store_o,
  output logic [CH_W-1:0]        dec_channel_o,
  output logic                   dec_no_match_o,
  output logic [2:0]             dec_class_o,
  output logic [15:0]            dec_store_len_o,
  output logic                   dec_keep_fcs_o,
  // Descriptor marking and interrupts
  output logic                   desc_mark_o,
  output logic [31:0]            desc_mark_addr_o,
  output logic [NUM_CH-1:0]      rx_chan_int_o
);

  // Refuse parameter sets the logic cannot serve, at elaboration
  if (NUM_CH != (1 << CH_W) || CNT_W != 16) begin : g_param_check
    $error("erbf_top: unsupported parameters");
  end

  // ==========================================================
  // Register decode
  logic [2:0]        region;
  logic [CH_W-1:0]   reg_ch;
  logic              wr_cfg;
  logic              wr_free;
  logic              wr_cp;
  logic              wr_hdp;

  assign region  = reg_addr_i[7:5];
  assign reg_ch  = reg_addr_i[2 +: CH_W];
  assign wr_cfg  = reg_wr_i && region == REGION_CONFIG;
  assign wr_free = reg_wr_i && region == REGION_FREE_CNT;
  assign wr_cp   = reg_wr_i && region == REGION_COMPL_PTR;
  assign wr_hdp  = reg_wr_i && region == REGION_HEAD_PTR;

  // ==========================================================
  // Configuration registers
  logic [15:0]       filter_cfg_q;
  logic [15:0]       max_len_q;
  logic [15:0]       low_thresh_q;
  logic [NUM_CH-1:0] chan_en_q;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      filter_cfg_q <= '0;
      max_len_q    <= MAX_LEN_RESET;
      low_thresh_q <= '0;
      chan_en_q    <= '0;
    end else if (wr_cfg) begin
      // Enables change only by host write, never by shutdown
      case (reg_addr_i)
        OFS_FILTER_CFG:  filter_cfg_q <= reg_wdata_i[15:0];
        OFS_MAX_LEN:     max_len_q    <= reg_wdata_i[15:0];
        OFS_LOW_THRESH:  low_thresh_q <= reg_wdata_i[15:0];
        OFS_CHAN_ENABLE: chan_en_q    <= reg_wdata_i[NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  logic            keep_fcs_bytes;
  logic            error_frame_enable;
  logic            all_frames_enable;
  logic            control_frame_enable;
  logic            short_frame_enable;
  logic            qos_enable;
  logic [CH_W-1:0] catchall_channel_select;

  assign keep_fcs_bytes          = filter_cfg_q[CFG_KEEP_FCS];
  assign error_frame_enable      = filter_cfg_q[CFG_ERROR_EN];
  assign all_frames_enable       = filter_cfg_q[CFG_ALL_EN];
  assign control_frame_enable    = filter_cfg_q[CFG_CONTROL_EN];
  assign short_frame_enable      = filter_cfg_q[CFG_SHORT_EN];
  assign qos_enable              = filter_cfg_q[CFG_QOS_EN];
  assign catchall_channel_select = filter_cfg_q[CFG_CATCHALL_LSB +: CH_W];

  // ==========================================================
  // Free-buffer counters
  logic [NUM_CH*CNT_W-1:0] free_cnt;

  // Host keeps these meaningful only when QOS or flow control is on
  erbf_free_count_bank #(
    .NUM_CH (NUM_CH),
    .CH_W   (CH_W),
    .CNT_W  (CNT_W)
  ) u_free_count_bank (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .add_we_i  (wr_free),
    .add_ch_i  (reg_ch),
    .add_val_i (reg_wdata_i[CNT_W-1:0]),
    .use_i     (buf_used_i),
    .use_ch_i  (buf_used_ch_i),
    .count_o   (free_cnt)
  );

  // ==========================================================
  // Channel shutdown sequencer
  erbf_state_t        sd_state_q;
  logic [NUM_CH-1:0]  sd_pend_q;
  logic [CH_W-1:0]    sd_ch_q;
  logic [31:0]        head_ptr_q [NUM_CH];
  logic [CH_W-1:0]    pend_pick;
  logic               pend_any;
  logic               sd_clear_hdp;
  logic               sd_done;

  always_comb begin
    pend_pick = '0;
    pend_any  = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (sd_pend_q[i]) begin
        pend_pick = CH_W'(i);
        pend_any  = 1'b1;
      end
    end
  end

  // Commands may arrive any time; a new one on the active channel re-arms
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sd_pend_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_cfg && reg_addr_i == OFS_SHUTDOWN_CMD &&
            reg_wdata_i[CH_W-1:0] == CH_W'(i)) begin
          sd_pend_q[i] <= 1'b1;
        end else if (sd_state_q == SD_IDLE && pend_any &&
                     pend_pick == CH_W'(i)) begin
          sd_pend_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sd_state_q <= SD_IDLE;
      sd_ch_q    <= '0;
    end else begin
      case (sd_state_q)
        SD_IDLE: begin
          if (pend_any) begin
            sd_ch_q    <= pend_pick;
            sd_state_q <= SD_WAIT;
          end
        end
        SD_WAIT: begin
          // Let the frame in reception complete first
          if (!rx_frame_busy_i) begin
            if (!chan_en_q[sd_ch_q]) begin
              sd_state_q <= SD_DONE; // No descriptor to touch
            end else if (head_ptr_q[sd_ch_q] != '0) begin
              sd_state_q <= SD_MARK;
            end else begin
              sd_state_q <= SD_CLEAR;
            end
          end
        end
        SD_MARK:  sd_state_q <= SD_CLEAR;
        SD_CLEAR: sd_state_q <= SD_DONE;
        SD_DONE:  sd_state_q <= SD_IDLE;
        default:  sd_state_q <= SD_IDLE;
      endcase
    end
  end

  assign sd_clear_hdp = sd_state_q == SD_CLEAR;
  assign sd_done      = sd_state_q == SD_DONE;

  // Descriptor flag write pulse, addressed at the next descriptor
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      desc_mark_o      <= 1'b0;
      desc_mark_addr_o <= '0;
    end else begin
      desc_mark_o <= sd_state_q == SD_MARK;
      if (sd_state_q == SD_MARK) begin
        desc_mark_addr_o <= head_ptr_q[sd_ch_q];
      end
    end
  end

  // ==========================================================
  // Head pointers, completion pointers, channel interrupts
  logic [31:0] compl_ptr_q [NUM_CH];

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    logic hit_reg;
    logic hit_sd;

    assign hit_reg = reg_ch == CH_W'(ch);
    assign hit_sd  = sd_ch_q == CH_W'(ch);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        head_ptr_q[ch] <= '0;
      end else if (sd_clear_hdp && hit_sd) begin
        head_ptr_q[ch] <= '0; // Cleared after the mark
      end else if (wr_hdp && hit_reg) begin
        head_ptr_q[ch] <= reg_wdata_i;
      end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        compl_ptr_q[ch] <= '0;
      end else if (sd_done && hit_sd) begin
        compl_ptr_q[ch] <= SHUTDOWN_CODE;
      end else if (wr_cp && hit_reg) begin
        compl_ptr_q[ch] <= reg_wdata_i;
      end
    end

    // Set beats an acknowledge landing in the same cycle
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        rx_chan_int_o[ch] <= 1'b0;
      end else if (sd_done && hit_sd) begin
        rx_chan_int_o[ch] <= 1'b1;
      end else if (wr_cp && hit_reg && reg_wdata_i == SHUTDOWN_CODE) begin
        rx_chan_int_o[ch] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Frame classification
  logic        any_err;
  logic        is_long;
  logic        is_short;
  erbf_class_t frame_class;

  assign any_err  = crc_err_i || code_err_i || align_err_i;
  assign is_long  = frame_len_i > max_len_q;
  assign is_short = frame_len_i < MIN_FRAME_LEN;

  always_comb begin
    if (is_long) begin
      frame_class = any_err ? CLS_JABBER : CLS_OVERSIZE;
    end else if (is_short) begin
      frame_class = any_err ? CLS_FRAGMENT : CLS_UNDERSIZE;
    end else begin
      frame_class = any_err ? CLS_BAD_CRC : CLS_PROPER;
    end
  end

  // ==========================================================
  // Address match and storage decision
  logic            drop_marked;
  logic            addr_match;
  logic            class_ok;
  logic            store;
  logic [CH_W-1:0] dest_ch;
  logic            low_prio;
  logic            qos_drop;
  logic [15:0]     dest_free;

  assign drop_marked = addr_hit_i && !match_or_drop_bit_i;
  // Hit on a disabled channel or gated control frame is non-matching
  assign addr_match = addr_hit_i && match_or_drop_bit_i &&
                      chan_en_q[addr_hit_ch_i] &&
                      (!control_frame_i || control_frame_enable);

  always_comb begin
    case (frame_class)
      CLS_PROPER:    class_ok = 1'b1;
      CLS_OVERSIZE:  class_ok = error_frame_enable;
      CLS_JABBER:    class_ok = error_frame_enable;
      CLS_BAD_CRC:   class_ok = error_frame_enable;
      CLS_UNDERSIZE: class_ok = short_frame_enable;
      CLS_FRAGMENT:  class_ok = short_frame_enable && error_frame_enable;
      default:       class_ok = 1'b0;
    endcase
    // Control frames need their own enable on either path
    if (control_frame_i && !control_frame_enable) begin
      class_ok = 1'b0;
    end
  end

  assign dest_ch = addr_match ? addr_hit_ch_i
                              : catchall_channel_select;
  assign dest_free = free_cnt[dest_ch*CNT_W +: CNT_W];
  assign low_prio  = !(vlan_tagged_i && vlan_prio_i >= HIGH_PRIO_MIN);
  assign qos_drop  = qos_enable && low_prio &&
                     dest_free <= low_thresh_q;

  always_comb begin
    if (drop_marked) begin
      store = 1'b0;
    end else if (addr_match) begin
      store = class_ok;
    end else begin
      store = all_frames_enable && class_ok;
    end
    if (qos_drop) begin
      store = 1'b0;
    end
  end

  // ==========================================================
  // Stored length and FCS handling
  logic [15:0] store_len;
  logic        keep_fcs;

  always_comb begin
    keep_fcs = keep_fcs_bytes || frame_len_i <= SHORT_CRC_LEN;
    if (is_long && error_frame_enable) begin
      store_len = max_len_q; // Truncate, FCS setting ignored
      keep_fcs  = 1'b1;
    end else if (keep_fcs) begin
      store_len = frame_len_i;
    end else begin
      store_len = frame_len_i - FCS_BYTES;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dec_valid_o     <= 1'b0;
      dec_store_o     <= 1'b0;
      dec_channel_o   <= '0;
      dec_no_match_o  <= 1'b0;
      dec_class_o     <= CLS_PROPER;
      dec_store_len_o <= '0;
      dec_keep_fcs_o  <= 1'b0;
    end else begin
      dec_valid_o <= frame_end_i;
      if (frame_end_i) begin
        dec_store_o     <= store;
        dec_channel_o   <= dest_ch;
        dec_no_match_o  <= !addr_match;
        dec_class_o     <= frame_class;
        dec_store_len_o <= store_len;
        dec_keep_fcs_o  <= keep_fcs;
      end
    end
  end

  // ==========================================================
  // Register read-back
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (region)
        REGION_CONFIG: begin
          case (reg_addr_i)
            OFS_FILTER_CFG:  reg_rdata_o <= {16'h0000, filter_cfg_q};
            OFS_MAX_LEN:     reg_rdata_o <= {16'h0000, max_len_q};
            OFS_LOW_THRESH:  reg_rdata_o <= {16'h0000, low_thresh_q};
            OFS_CHAN_ENABLE: reg_rdata_o <= 32'(chan_en_q);
            OFS_INT_STATUS:  reg_rdata_o <= 32'(rx_chan_int_o);
            default:         reg_rdata_o <= '0;
          endcase
        end
        REGION_FREE_CNT:
          reg_rdata_o <= 32'(free_cnt[reg_ch*CNT_W +: CNT_W]);
        REGION_COMPL_PTR: reg_rdata_o <= compl_ptr_q[reg_ch];
        REGION_HEAD_PTR:  reg_rdata_o <= head_ptr_q[reg_ch];
        default:          reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule // erbf_top

// ==== dv/erbf_top_monitor.sv ====
// Purpose: Port checks for the receive buffer/shutdown/filter block
// Assumes: One clock domain, reset_i async active high
// Notes:   Bound to erbf_top from the bench top file
`timescale 1ns/10ps
module erbf_top_monitor
  import erbf_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input wire logic              sys_clk_i,
  input wire logic              reset_i,
  // Frame report
  input wire logic              frame_end_i,
  input wire logic [15:0]       frame_len_i,
  input wire logic              crc_err_i,
  input wire logic              code_err_i,
  input wire logic              align_err_i,
  input wire logic              addr_hit_i,
  input wire logic              match_or_drop_bit_i,
  // Decision and shutdown
  input wire logic              dec_valid_o,
  input wire logic              dec_store_o,
  input wire logic              dec_no_match_o,
  input wire logic [2:0]        dec_class_o,
  input wire logic [15:0]       dec_store_len_o,
  input wire logic              dec_keep_fcs_o,
  input wire logic              desc_mark_o,
  input wire logic [NUM_CH-1:0] rx_chan_int_o
);
  // ==========
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  logic any_err;
  assign any_err = crc_err_i | code_err_i | align_err_i;
  sequence s_short_end;
    frame_end_i && (frame_len_i < MIN_FRAME_LEN);
  endsequence
  a_dec_answer: assert property (
    frame_end_i |=> dec_valid_o) else $error("decision missing");
  a_dec_cause: assert property (
    dec_valid_o |-> $past(frame_end_i)) else $error("stray decision");
  a_short_clean: assert property (
    s_short_end ##0 !any_err |=> dec_class_o == CLS_UNDERSIZE)
    else $error("clean short frame misclassified");
  a_short_err: assert property (
    s_short_end ##0 any_err |=> dec_class_o == CLS_FRAGMENT)
    else $error("errored short frame misclassified");
  a_tiny_fcs: assert property (
    frame_end_i && frame_len_i <= SHORT_CRC_LEN |=> dec_keep_fcs_o
    && dec_store_len_o == $past(frame_len_i)) else $error("tiny fcs cut");
  a_drop_hit: assert property (
    frame_end_i && addr_hit_i && !match_or_drop_bit_i |=> !dec_store_o)
    else $error("drop-marked frame stored");
  a_nomatch_flag: assert property (
    frame_end_i && !addr_hit_i |=> dec_no_match_o)
    else $error("unmatched frame not flagged");
  a_mark_pulse: assert property (
    desc_mark_o |=> !desc_mark_o) else $error("mark pulse too long");
  a_mark_int: assert property (
    desc_mark_o |-> ##[1:6] (rx_chan_int_o != '0))
    else $error("no interrupt after mark");
endmodule // erbf_top_monitor

// ==== dv/erbf_rx_front_model.sv ====
// Purpose: Front end model reporting received frames
// Assumes: One report at a time, called from the bench
// Notes:   Length lines are scrambled between reports
`timescale 1ns/10ps
module erbf_rx_front_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Frame reports
  output logic             busy_o,
  output logic             end_o,
  output logic [15:0]      len_o,
  output logic [2:0]       err_o,
  output logic             ctrl_o,
  output logic [3:0]       tag_o,
  output logic [4:0]       hit_o
);
  // ==========
  // Report drivers
  initial begin
    busy_o = 1'b0;
    end_o = 1'b0;
    len_o = 16'h0000;
    err_o = 3'h0;
    ctrl_o = 1'b0;
    tag_o = 4'h0;
    hit_o = 5'h00;
  end
  // Busy is held across a shutdown so the frame can finish first
  task automatic hold_busy(input logic b);
    @(posedge sys_clk_i);
    busy_o <= b;
  endtask
  task automatic report(input logic [15:0] l, input logic [2:0] e,
    input logic c, input logic [3:0] t, input logic [4:0] h);
    @(posedge sys_clk_i);
    end_o <= 1'b1;
    len_o <= l;
    err_o <= e;
    ctrl_o <= c;
    tag_o <= t;
    hit_o <= h;
    @(posedge sys_clk_i);
    end_o <= 1'b0;
    len_o <= ~l; // Stale length must never look valid
  endtask
endmodule // erbf_rx_front_model

// ==== dv/erbf_top_tb.sv ====
// Purpose: Self-checking bench for erbf_top
// Assumes: Host register port plus a modelled front end
// Notes:   Max length is cut to 100 so long frames stay brief
`timescale 1ns/10ps
module erbf_top_tb
  import erbf_pkg::*;
  ;
  logic        sys_clk_i, reset_i, reg_wr_i, reg_rd_i, buf_used_i;
  logic [7:0]  reg_addr_i, rx_chan_int_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, desc_mark_addr_o, mark_addr;
  logic [2:0]  buf_used_ch_i, vlan_prio_i, addr_hit_ch_i, dec_channel_o;
  logic [2:0]  dec_class_o;
  logic [15:0] frame_len_i, dec_store_len_o;
  logic        rx_frame_busy_i, frame_end_i, crc_err_i, code_err_i;
  logic        align_err_i, control_frame_i, vlan_tagged_i, addr_hit_i;
  logic        match_or_drop_bit_i, dec_valid_o, dec_store_o;
  logic        dec_no_match_o, dec_keep_fcs_o, desc_mark_o;
  int          failures = 0, checked = 0, cycles = 0, marks = 0;
  erbf_top DUT (.*);
  erbf_rx_front_model front (.sys_clk_i(sys_clk_i),
    .busy_o(rx_frame_busy_i), .end_o(frame_end_i), .len_o(frame_len_i),
    .err_o({crc_err_i, code_err_i, align_err_i}), .ctrl_o(control_frame_i),
    .tag_o({vlan_tagged_i, vlan_prio_i}),
    .hit_o({addr_hit_i, match_or_drop_bit_i, addr_hit_ch_i}));
  // ==========
  // Clock, marks and timeout
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (desc_mark_o === 1'b1) begin
      marks++;
      mark_addr = desc_mark_addr_o;
    end
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  // ==========
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("read data", e, reg_rdata_o);
  endtask
  task automatic use_buf(input logic [2:0] c);
    @(posedge sys_clk_i);
    buf_used_i <= 1'b1;
    buf_used_ch_i <= c;
    @(posedge sys_clk_i);
    buf_used_i <= 1'b0;
  endtask
  task automatic wait_int(input logic [2:0] c);
    for (int i = 0; i < 40 && rx_chan_int_o[c] !== 1'b1; i++)
      @(posedge sys_clk_i);
    chk("interrupt", 32'h1, rx_chan_int_o[c]);
  endtask
  // x holds {store, channel}
  task automatic fr(input logic [15:0] l, input logic [2:0] e, input logic c,
    input logic [3:0] t, input logic [4:0] h, input logic [3:0] x,
    input erbf_class_t k, input logic [15:0] sl);
    front.report(l, e, c, t, h);
    #1;
    chk("valid", 32'h1, dec_valid_o);
    chk("store", x[3], dec_store_o);
    chk("class", k, dec_class_o);
    if (x[3]) begin
      chk("channel", x[2:0], dec_channel_o);
      chk("length", sl, dec_store_len_o);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    reset_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    buf_used_i = 1'b0;
    buf_used_ch_i = 3'h0;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(OFS_MAX_LEN, 32'h0000_05ee);
    rd(8'hfc, 32'h0);
    wr(8'h40, 32'h5);
    wr(8'h40, 32'h3);
    rd(8'h40, 32'h8);
    use_buf(3'h0);
    use_buf(3'h0);
    rd(8'h40, 32'h6);
    wr(8'h44, 32'hffff);
    wr(8'h44, 32'h2);
    rd(8'h44, 32'hffff);
    use_buf(3'h2);
    rd(8'h48, 32'h0);
    wr(OFS_MAX_LEN, 32'h64);
    wr(OFS_CHAN_ENABLE, 32'h8);
    wr(OFS_FILTER_CFG, 32'h516);
    fr(16'h40, 3'h0, 1'h0, 4'h0, 5'h00, 4'hd, CLS_PROPER, 16'h3c);
    fr(16'h64, 3'h0, 1'h0, 4'h0, 5'h00, 4'hd, CLS_PROPER, 16'h60);
    fr(16'h65, 3'h0, 1'h0, 4'h0, 5'h00, 4'hd, CLS_OVERSIZE, 16'h64);
    fr(16'h65, 3'h4, 1'h0, 4'h0, 5'h00, 4'hd, CLS_JABBER, 16'h64);
    fr(16'h3f, 3'h0, 1'h0, 4'h0, 5'h00, 4'hd, CLS_UNDERSIZE, 16'h3b);
    fr(16'h14, 3'h4, 1'h0, 4'h0, 5'h00, 4'hd, CLS_FRAGMENT, 16'h14);
    fr(16'h40, 3'h4, 1'h0, 4'h0, 5'h00, 4'hd, CLS_BAD_CRC, 16'h3c);
    fr(16'h40, 3'h0, 1'h1, 4'h0, 5'h00, 4'h0, CLS_PROPER, 16'h0);
    fr(16'h40, 3'h0, 1'h0, 4'h0, 5'h1e, 4'hd, CLS_PROPER, 16'h3c);
    fr(16'h40, 3'h0, 1'h0, 4'h0, 5'h1b, 4'hb, CLS_PROPER, 16'h3c);
    fr(16'h40, 3'h0, 1'h0, 4'h0, 5'h13, 4'h0, CLS_PROPER, 16'h0);
    wr(OFS_FILTER_CFG, 32'h502);
    fr(16'h40, 3'h0, 1'h0, 4'h0, 5'h00, 4'h0, CLS_PROPER, 16'h0);
    fr(16'h65, 3'h4, 1'h0, 4'h0, 5'h1b, 4'hb, CLS_JABBER, 16'h64);
    fr(16'h30, 3'h4, 1'h0, 4'h0, 5'h1b, 4'h0, CLS_FRAGMENT, 16'h0);
    wr(OFS_FILTER_CFG, 32'h50a);
    fr(16'h40, 3'h0, 1'h1, 4'h0, 5'h1b, 4'hb, CLS_PROPER, 16'h3c);
    wr(OFS_CHAN_ENABLE, 32'h9);
    wr(OFS_LOW_THRESH, 32'h6);
    wr(OFS_FILTER_CFG, 32'h522);
    fr(16'h40, 3'h0, 1'h0, 4'h0, 5'h18, 4'h0, CLS_PROPER, 16'h0);
    fr(16'h40, 3'h0, 1'h0, 4'hc, 5'h18, 4'h8, CLS_PROPER, 16'h3c);
    wr(8'h8c, 32'h1000);
    front.hold_busy(1'b1);
    wr(OFS_SHUTDOWN_CMD, 32'h3);
    repeat (6) @(posedge sys_clk_i);
    chk("early mark", 32'h0, marks);
    front.hold_busy(1'b0);
    wait_int(3'h3);
    chk("marks", 32'h1, marks);
    chk("mark address", 32'h1000, mark_addr);
    rd(8'h6c, SHUTDOWN_CODE);
    rd(8'h8c, 32'h0);
    rd(OFS_CHAN_ENABLE, 32'h9);
    wr(8'h6c, SHUTDOWN_CODE);
    @(posedge sys_clk_i);
    #1;
    chk("ack interrupt", 32'h0, rx_chan_int_o[3]);
    wr(OFS_SHUTDOWN_CMD, 32'h6);
    wait_int(3'h6);
    rd(8'h78, SHUTDOWN_CODE);
    rd(OFS_INT_STATUS, 32'h40);
    chk("idle marks", 32'h1, marks);
    finish_test();
  end
endmodule // erbf_top_tb
bind erbf_top erbf_top_monitor #(.NUM_CH(NUM_CH)) u_mon (.*);
